// *** rtl/pint_engine.sv ***
// Pin interrupt and pattern match engine with register port
// Operation
// - Eight selectable pin slots, each with its own interrupt output line.
// - Edge slots interrupt on rising, falling or both edges as selected.
// - Level slots request while the pin sits at the chosen active level.
// - Pin interrupt requests drive a wake request toward the power manager.
// - Pattern mode feeds up to eight slots into a programmable expression.
// - Every product term raises its own dedicated interrupt request.
// - A pattern match may also pulse the CPU event input.
// - Pattern match never produces a wake request.
// - Pin routing into slots is done outside by the system control block.
// - Register accesses complete in a single cycle, never wait.
// - Slot zero and one interrupts also serve as DMA triggers.
`timescale 1ns/1ps
module pint_engine #(
    parameter int NUM_SLOTS = pint_pkg::NSLOT
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  slotPin,
    input  wire logic [7:0]  busAddr,
    input  wire logic [31:0] busWdata,
    input  wire logic        busWrite,
    input  wire logic        busRead,
    output logic      [31:0] busRdata,
    output logic      [7:0]  pinIrq,
    output logic      [1:0]  dmaTrig,
    output logic             cpuEvent,
    output logic             wakeReq,
    output logic             irq
);

    // Register fields are eight bits wide, so no other slot count fits
    if (NUM_SLOTS != pint_pkg::NSLOT) begin : gBadSlots
        $error("pint_engine: register layout serves exactly 8 slots");
    end

    logic [7:0]  mode;       // 1 = level sensitive
    logic [7:0]  riseEn;     // Edge: rising enable, level: enable
    logic [7:0]  fallEn;     // Edge: falling enable, level: active high
    logic [7:0]  riseLatch;
    logic [7:0]  fallLatch;
    logic [15:0] pmCtrl;
    logic [23:0] pmSrc;
    logic [23:0] pmCond;
    logic [7:0]  sliceRise;
    logic [7:0]  sliceFall;
    logic [7:0]  termPrev;
    logic [15:0] intStat;
    logic [15:0] intMask;

    logic [7:0]  next_mode;
    logic [7:0]  next_riseEn;
    logic [7:0]  next_fallEn;
    logic [7:0]  next_riseLatch;
    logic [7:0]  next_fallLatch;
    logic [15:0] next_pmCtrl;
    logic [23:0] next_pmSrc;
    logic [23:0] next_pmCond;
    logic [7:0]  next_sliceRise;
    logic [7:0]  next_sliceFall;
    logic [7:0]  next_termPrev;
    logic [15:0] next_intStat;
    logic [15:0] next_intMask;
    logic [31:0] next_busRdata;
    logic [7:0]  next_pinIrq;
    logic [1:0]  next_dmaTrig;
    logic        next_cpuEvent;
    logic        next_wakeReq;
    logic        next_irq;

    logic [7:0]  lvl;
    logic [7:0]  rise;
    logic [7:0]  fall;
    logic [7:0]  pinReqNow;
    logic [7:0]  term;
    logic [7:0]  termEv;
    logic        patternMode;
    logic        eventEn;

    // Slot inputs arrive already routed by the system control block
    for (genvar g = 0; g < 8; g++) begin : gSlot
        pint_sync_edge uSync (
            .clk   (clk),
            .rst_n (rst_n),
            .pin   (slotPin[g]),
            .level (lvl[g]),
            .rise  (rise[g]),
            .fall  (fall[g])
        );
    end

    function automatic logic wr_hit(input logic       wr,
                                    input logic [7:0] addr,
                                    input logic [7:0] reg_addr);
        wr_hit = wr && (addr == reg_addr);
    endfunction

    function automatic logic slice_match(input logic [2:0] cond,
                                         input logic       lv,
                                         input logic       rs,
                                         input logic       fs,
                                         input logic       rNow,
                                         input logic       fNow);
        case (pint_pkg::pint_cond_e'(cond))
            pint_pkg::COND_ONE:         slice_match = 1'b1;
            pint_pkg::COND_RISE_STICKY: slice_match = rs;
            pint_pkg::COND_FALL_STICKY: slice_match = fs;
            pint_pkg::COND_EDGE_STICKY: slice_match = rs | fs;
            pint_pkg::COND_HIGH:        slice_match = lv;
            pint_pkg::COND_LOW:         slice_match = ~lv;
            pint_pkg::COND_ZERO:        slice_match = 1'b0;
            default:                    slice_match = rNow | fNow;
        endcase
    endfunction

    always_comb begin
        logic [7:0]  clrRise;
        logic [7:0]  clrFall;
        logic [15:0] clrStat;
        logic        clrSlice;
        logic        acc;
        logic [2:0]  src;
        logic        sl;
        clrRise  = 8'h00;
        clrFall  = 8'h00;
        clrStat  = 16'h0000;
        clrSlice = 1'b0;
        acc      = 1'b1;
        src      = 3'h0;
        sl       = 1'b0;

        next_mode    = mode;
        next_riseEn  = riseEn;
        next_fallEn  = fallEn;
        next_pmCtrl  = pmCtrl;
        next_pmSrc   = pmSrc;
        next_pmCond  = pmCond;
        next_intMask = intMask;
        patternMode  = pmCtrl[pint_pkg::PMCTRL_PATTERN_BIT];
        eventEn      = pmCtrl[pint_pkg::PMCTRL_EVENT_BIT];

        if (wr_hit(busWrite, busAddr, pint_pkg::ADDR_MODE)) begin
            next_mode = busWdata[7:0];
        end else if (wr_hit(busWrite, busAddr, pint_pkg::ADDR_RISEN)) begin
            next_riseEn = busWdata[7:0];
        end else if (wr_hit(busWrite, busAddr, pint_pkg::ADDR_FALLEN)) begin
            next_fallEn = busWdata[7:0];
        end else if (wr_hit(busWrite, busAddr, pint_pkg::ADDR_RISE)) begin
            clrRise = busWdata[7:0];
        end else if (wr_hit(busWrite, busAddr, pint_pkg::ADDR_FALL)) begin
            clrFall = busWdata[7:0];
        end else if (wr_hit(busWrite, busAddr, pint_pkg::ADDR_REQ)) begin
            clrRise = busWdata[7:0];
            clrFall = busWdata[7:0];
        end else if (wr_hit(busWrite, busAddr, pint_pkg::ADDR_PMCTRL)) begin
            next_pmCtrl = busWdata[15:0];
        end else if (wr_hit(busWrite, busAddr, pint_pkg::ADDR_PMSRC)) begin
            next_pmSrc = busWdata[23:0];
            clrSlice   = 1'b1;
        end else if (wr_hit(busWrite, busAddr, pint_pkg::ADDR_PMCOND)) begin
            next_pmCond = busWdata[23:0];
            clrSlice    = 1'b1;
        end else if (wr_hit(busWrite, busAddr, pint_pkg::ADDR_INTSTAT)) begin
            clrStat = busWdata[15:0];
        end else if (wr_hit(busWrite, busAddr, pint_pkg::ADDR_INTMASK)) begin
            next_intMask = busWdata[15:0];
        end

        // A new edge in the clearing cycle survives: set wins over clear
        next_riseLatch = (riseLatch & ~clrRise)
                       | (rise & riseEn & ~mode);
        next_fallLatch = (fallLatch & ~clrFall)
                       | (fall & fallEn & ~mode);
        pinReqNow = (~mode & (riseLatch | fallLatch))
                  | (mode & riseEn & ~(lvl ^ fallEn));

        // Sticky slice edges restart whenever the source or condition selection is written; PMCTRL writes keep them
        next_sliceRise = sliceRise;
        next_sliceFall = sliceFall;
        term           = 8'h00;
        for (int i = 0; i < 8; i++) begin
            src = pmSrc[3*i +: 3];
            next_sliceRise[i] = (sliceRise[i] & ~clrSlice) | rise[src];
            next_sliceFall[i] = (sliceFall[i] & ~clrSlice) | fall[src];
            sl  = slice_match(pmCond[3*i +: 3], lvl[src], sliceRise[i],
                              sliceFall[i], rise[src], fall[src]);
            acc = acc & sl;
            if (pmCtrl[pint_pkg::PMCTRL_ENDPT_LSB + i]) begin
                term[i] = acc;
                acc     = 1'b1;
            end
        end
        termEv        = term & ~termPrev;
        next_termPrev = term;

        next_pinIrq   = patternMode ? term : pinReqNow;
        next_dmaTrig  = next_pinIrq[1:0];
        next_cpuEvent = patternMode & eventEn & (|termEv);
        // Registered wake request: needs the clock, see hand-over limits
        next_wakeReq  = ~patternMode & (|pinReqNow);

        next_intStat = (intStat & ~clrStat)
                     | {termEv & {8{patternMode}},
                        pinReqNow & {8{~patternMode}}};
        next_irq     = |(intStat & intMask);

        next_busRdata = 32'h00000000;
        if (busRead) begin
            if (busAddr == pint_pkg::ADDR_MODE) begin
                next_busRdata = {24'h000000, mode};
            end else if (busAddr == pint_pkg::ADDR_RISEN) begin
                next_busRdata = {24'h000000, riseEn};
            end else if (busAddr == pint_pkg::ADDR_FALLEN) begin
                next_busRdata = {24'h000000, fallEn};
            end else if (busAddr == pint_pkg::ADDR_RISE) begin
                next_busRdata = {24'h000000, riseLatch};
            end else if (busAddr == pint_pkg::ADDR_FALL) begin
                next_busRdata = {24'h000000, fallLatch};
            end else if (busAddr == pint_pkg::ADDR_REQ) begin
                next_busRdata = {24'h000000, pinIrq};
            end else if (busAddr == pint_pkg::ADDR_PMCTRL) begin
                next_busRdata = {term, 8'h00, pmCtrl};
            end else if (busAddr == pint_pkg::ADDR_PMSRC) begin
                next_busRdata = {8'h00, pmSrc};
            end else if (busAddr == pint_pkg::ADDR_PMCOND) begin
                next_busRdata = {8'h00, pmCond};
            end else if (busAddr == pint_pkg::ADDR_INTSTAT) begin
                next_busRdata = {16'h0000, intStat};
            end else if (busAddr == pint_pkg::ADDR_INTMASK) begin
                next_busRdata = {16'h0000, intMask};
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode      <= pint_pkg::RST_BYTE;
            riseEn    <= pint_pkg::RST_BYTE;
            fallEn    <= pint_pkg::RST_BYTE;
            riseLatch <= pint_pkg::RST_BYTE;
            fallLatch <= pint_pkg::RST_BYTE;
            pmCtrl    <= pint_pkg::RST_HALF;
            pmSrc     <= pint_pkg::RST_SRC;
            pmCond    <= pint_pkg::RST_COND;
            sliceRise <= pint_pkg::RST_BYTE;
            sliceFall <= pint_pkg::RST_BYTE;
            termPrev  <= pint_pkg::RST_BYTE;
            intStat   <= pint_pkg::RST_HALF;
            intMask   <= pint_pkg::RST_HALF;
            busRdata  <= 32'h00000000;
            pinIrq    <= pint_pkg::RST_BYTE;
            dmaTrig   <= 2'h0;
            cpuEvent  <= 1'b0;
            wakeReq   <= 1'b0;
            irq       <= 1'b0;
        end else begin
            mode      <= next_mode;
            riseEn    <= next_riseEn;
            fallEn    <= next_fallEn;
            riseLatch <= next_riseLatch;
            fallLatch <= next_fallLatch;
            pmCtrl    <= next_pmCtrl;
            pmSrc     <= next_pmSrc;
            pmCond    <= next_pmCond;
            sliceRise <= next_sliceRise;
            sliceFall <= next_sliceFall;
            termPrev  <= next_termPrev;
            intStat   <= next_intStat;
            intMask   <= next_intMask;
            busRdata  <= next_busRdata;
            pinIrq    <= next_pinIrq;
            dmaTrig   <= next_dmaTrig;
            cpuEvent  <= next_cpuEvent;
            wakeReq   <= next_wakeReq;
            irq       <= next_irq;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_read_single_cycle: assert property (
        busRead && busAddr == pint_pkg::ADDR_RISEN
        |=> busRdata == {24'h000000, $past(riseEn)})
        else $error("read data not returned next cycle");

    a_rise_to_irq: assert property (
        !patternMode && !mode[0] && riseEn[0] && rise[0] && !busWrite
        ##1 !patternMode && !busWrite |=> pinIrq[0])
        else $error("rising edge did not raise slot zero request");

    a_level_active: assert property (
        !patternMode && mode[0] && riseEn[0] && (lvl[0] == fallEn[0])
        |=> pinIrq[0])
        else $error("active level did not hold request");

    a_level_idle: assert property (
        !patternMode && mode[0] && (lvl[0] != fallEn[0]) |=> !pinIrq[0])
        else $error("inactive level still requests");

    a_dma_mirror: assert property (
        dmaTrig == pinIrq[1:0])
        else $error("DMA triggers differ from slot requests");

    a_no_pattern_wake: assert property (
        patternMode |=> !wakeReq)
        else $error("pattern mode produced a wake request");

    a_pin_wake: assert property (
        !patternMode && (pinReqNow != 8'h00) |=> wakeReq)
        else $error("pin request did not wake");

    a_event_pulse: assert property (
        cpuEvent |-> $past(patternMode && eventEn && termEv != 8'h00))
        else $error("event pulse without a new term match");

    a_term_status: assert property (
        patternMode && termEv[0] |=> intStat[pint_pkg::INTSTAT_TERM_LSB])
        else $error("term match did not set status");

    a_irq_masked: assert property (
        (intStat & intMask) != 16'h0000 |=> irq)
        else $error("unmasked status did not raise irq");

    c_edge_irq:    cover property (!patternMode && rise[0] ##[1:3] pinIrq[0]);
    c_cpu_event:   cover property (cpuEvent);
    c_pattern_irq: cover property (patternMode && pinIrq != 8'h00 ##1 irq);

endmodule // pint_engine

// *** shared/pint_pkg.sv ***
// Constants shared by the pin interrupt and pattern match engine
package pint_pkg;

    localparam int          NSLOT        = 8;
    localparam int          ADDR_W       = 8;
    localparam int          SRC_W        = 3;

    localparam logic [7:0]  ADDR_MODE    = 8'h00;
    localparam logic [7:0]  ADDR_RISEN   = 8'h04;
    localparam logic [7:0]  ADDR_FALLEN  = 8'h08;
    localparam logic [7:0]  ADDR_RISE    = 8'h0c;
    localparam logic [7:0]  ADDR_FALL    = 8'h10;
    localparam logic [7:0]  ADDR_REQ     = 8'h14;
    localparam logic [7:0]  ADDR_PMCTRL  = 8'h18;
    localparam logic [7:0]  ADDR_PMSRC   = 8'h1c;
    localparam logic [7:0]  ADDR_PMCOND  = 8'h20;
    localparam logic [7:0]  ADDR_INTSTAT = 8'h24;
    localparam logic [7:0]  ADDR_INTMASK = 8'h28;

    localparam logic [7:0]  RST_BYTE     = 8'h00;
    localparam logic [15:0] RST_HALF     = 16'h0000;
    localparam logic [23:0] RST_SRC      = 24'h000000;
    localparam logic [23:0] RST_COND     = 24'h000000;

    localparam int          PMCTRL_PATTERN_BIT = 0;
    localparam int          PMCTRL_EVENT_BIT   = 1;
    localparam int          PMCTRL_ENDPT_LSB   = 8;
    localparam int          PMCTRL_TERMS_LSB   = 24;
    localparam int          INTSTAT_TERM_LSB   = 8;

    typedef enum logic [2:0] {
        COND_ONE         = 3'b000,
        COND_RISE_STICKY = 3'b001,
        COND_FALL_STICKY = 3'b010,
        COND_EDGE_STICKY = 3'b011,
        COND_HIGH        = 3'b100,
        COND_LOW         = 3'b101,
        COND_ZERO        = 3'b110,
        COND_EDGE_NOW    = 3'b111
    } pint_cond_e;

endpackage

// *** rtl/pint_sync_edge.sv ***
// Two-stage synchroniser with edge detection for one selected pin
`timescale 1ns/1ps
module pint_sync_edge (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic pin,
    output logic      level,
    output logic      rise,
    output logic      fall
);

    logic syncFirst;
    logic syncSecond;
    logic prevLevel;
    logic next_syncFirst;
    logic next_syncSecond;
    logic next_prevLevel;

    always_comb begin
        next_syncFirst  = pin;
        next_syncSecond = syncFirst;
        next_prevLevel  = syncSecond;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            syncFirst  <= 1'b0;
            syncSecond <= 1'b0;
            prevLevel  <= 1'b0;
        end else begin
            syncFirst  <= next_syncFirst;
            syncSecond <= next_syncSecond;
            prevLevel  <= next_prevLevel;
        end
    end

    // Edge is current versus previous synchronised sample
    assign level = syncSecond;
    assign rise  = syncSecond & ~prevLevel;
    assign fall  = ~syncSecond & prevLevel;

    a_edge_latency: assert property (@(posedge clk) disable iff (!rst_n)
        ##3 (rise == ($past(pin, 2) && !$past(pin, 3))))
        else $error("rise does not match pin history");

endmodule // pint_sync_edge

// *** testbench/pint_pin_model.sv ***
// Model of the routed input pins that feed the engine's slots
`timescale 1ns/1ps
module pint_pin_model (
    input  wire logic       clk,
    input  wire logic [7:0] target,
    input  wire logic [1:0] lag,
    output logic      [7:0] slotPin
);
    logic [31:0] hist = 32'h00000000;

    initial slotPin = 8'h00;

    always @(posedge clk) begin
        hist <= {hist[23:0], target};
    end

    // Pads settle 3 ns after the edge, never on it, with 0 to 3 cycles of
    // extra lag, so the engine sees changes at no fixed phase
    always @(hist or lag or target) begin
        if (lag == 2'd0)
            slotPin <= #3 target;
        else
            slotPin <= #3 hist[8 * (int'(lag) - 1) +: 8];
    end
endmodule // pint_pin_model

// *** testbench/pint_engine_tb_top.sv ***
// Self-checking bench for the pin interrupt and pattern match engine
`timescale 1ns/1ps
module pint_engine_tb_top;
    localparam logic [7:0]  REG_A [7] = '{8'h00, 8'h04, 8'h08, 8'h1c,
                                          8'h20, 8'h28, 8'h2c};
    localparam logic [31:0] REG_M [7] = '{32'hff, 32'hff, 32'hff,
                                          32'hffffff, 32'hffffff,
                                          32'hffff, 32'h0};
    localparam logic [7:0]  COND_T = 8'h1f;
    localparam logic [7:0]  EDGE_R = 8'h33;
    localparam logic [7:0]  EDGE_F = 8'h3c;
    localparam int          COND_EV [8] = '{0, 1, 1, 1, 1, 1, 0, 2};

    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  target = 8'h00;
    logic [1:0]  lag = 2'd0;
    logic [7:0]  slotPin;
    logic [7:0]  busAddr = 8'h00;
    logic [31:0] busWdata = 32'h0;
    logic        busWrite = 1'b0;
    logic        busRead = 1'b0;
    logic [31:0] busRdata;
    logic [7:0]  pinIrq;
    logic [1:0]  dmaTrig;
    logic        cpuEvent;
    logic        wakeReq;
    logic        irq;
    logic        rdPend = 1'b0;
    logic        en;
    logic [31:0] rv;
    logic [31:0] expQ [$];
    int          errTotal = 0;
    int          checkCount = 0;
    int          evCount = 0;
    int          evBase;
    int          seed = 4985;

    always #5 clk = ~clk;

    pint_pin_model pins_i (.clk(clk), .target(target), .lag(lag),
                           .slotPin(slotPin));

    pint_engine DUT (.clk(clk), .rst_n(rst_n), .slotPin(slotPin),
                     .busAddr(busAddr), .busWdata(busWdata),
                     .busWrite(busWrite), .busRead(busRead),
                     .busRdata(busRdata), .pinIrq(pinIrq),
                     .dmaTrig(dmaTrig), .cpuEvent(cpuEvent),
                     .wakeReq(wakeReq), .irq(irq));

    task automatic cmpVal(input logic [31:0] got, input logic [31:0] exp);
        checkCount++;
        if (got !== exp) begin
            errTotal++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmpRead(input logic [31:0] got);
        cmpVal(got, expQ.pop_front());
    endtask

    task automatic wrapUp;
        $display("checks %0d mismatches %0d", checkCount, errTotal);
        if (errTotal == 0 && checkCount > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        busAddr  <= a;
        busWdata <= d;
        busWrite <= 1'b1;
        @(posedge clk);
        busWrite <= 1'b0;
    endtask

    // The expected word is queued with the strobe; the monitor pops it
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        busAddr <= a;
        busRead <= 1'b1;
        expQ.push_back(e);
        @(posedge clk);
        busRead <= 1'b0;
    endtask

    task automatic pins(input logic [7:0] v);
        @(posedge clk);
        target <= v;
        lag    <= 2'($random(seed));
    endtask

    // Let the launching edge settle before looking at the flags
    task automatic flags(input logic [7:0] req, input logic i,
                         input logic w);
        #1;
        cmpVal(32'(pinIrq), 32'(req));
        cmpVal(32'(dmaTrig), 32'(req[1:0]));
        cmpVal(32'(wakeReq), 32'(w));
        cmpVal(32'(irq), 32'(i));
    endtask

    always @(posedge clk) begin
        if (rdPend)
            cmpRead(busRdata);
        else if (rst_n)
            cmpVal(busRdata, 32'h0);
        rdPend <= busRead;
        if (cpuEvent === 1'b1)
            evCount++;
    end

    initial begin
        #100000;
        errTotal++;
        wrapUp();
    end

    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        for (int a = 0; a < 11; a++)
            rd(8'(a * 4), 32'h0);
        rd(8'hfc, 32'h0);
        for (int i = 0; i < 7; i++) begin
            rv = $random(seed);
            wr(REG_A[i], rv);
            rd(REG_A[i], rv & REG_M[i]);
        end
        for (int i = 0; i < 6; i++)
            wr(REG_A[i], 32'h0);
        wt(6);
        wr(pint_pkg::ADDR_REQ, 32'hff);
        wr(pint_pkg::ADDR_INTSTAT, 32'hffff);
        wr(pint_pkg::ADDR_RISEN, 32'h33);
        wr(pint_pkg::ADDR_FALLEN, 32'h3c);
        wr(pint_pkg::ADDR_INTMASK, 32'h0f);
        for (int i = 0; i < 8; i++) begin
            for (int e = 0; e < 2; e++) begin
                pins(target ^ (8'h01 << i));
                wt(12);
                en = (e == 0) ? EDGE_R[i] : EDGE_F[i];
                rv = en ? 32'(8'h01 << i) : 32'h0;
                rd(pint_pkg::ADDR_REQ, rv);
                rd((e == 0) ? pint_pkg::ADDR_RISE : pint_pkg::ADDR_FALL,
                   rv);
                flags(rv[7:0], en && i < 4, en);
                if (i % 2 == 0)
                    wr(pint_pkg::ADDR_REQ, 32'(8'h01 << i));
                else if (e == 0)
                    wr(pint_pkg::ADDR_RISE, 32'(8'h01 << i));
                else
                    wr(pint_pkg::ADDR_FALL, 32'(8'h01 << i));
                wt(4);
                wr(pint_pkg::ADDR_INTSTAT, 32'hffff);
                wt(3);
                rd(pint_pkg::ADDR_REQ, 32'h0);
                flags(8'h00, 1'b0, 1'b0);
            end
        end
        wr(pint_pkg::ADDR_MODE, 32'hc0);
        wr(pint_pkg::ADDR_RISEN, 32'hc0);
        wr(pint_pkg::ADDR_FALLEN, 32'h40);
        wt(8);
        rd(pint_pkg::ADDR_REQ, 32'h80);
        pins(target | 8'hc0);
        wt(12);
        wr(pint_pkg::ADDR_REQ, 32'hc0);
        wt(4);
        rd(pint_pkg::ADDR_REQ, 32'h40);
        flags(8'h40, 1'b0, 1'b1);
        wr(pint_pkg::ADDR_PMSRC, 32'h0);
        pins(target | 8'h01);
        wr(pint_pkg::ADDR_PMCTRL, 32'h0103);
        for (int c = 0; c < 8; c++) begin
            wr(pint_pkg::ADDR_PMCOND, 32'(c));
            wt(12);
            evBase = evCount;
            pins(target & 8'hfe);
            wt(12);
            pins(target | 8'h01);
            wt(12);
            rv = 32'(COND_T[c]);
            rd(pint_pkg::ADDR_PMCTRL, (rv << 24) | 32'h0103);
            rd(pint_pkg::ADDR_REQ, rv);
            cmpVal(32'(evCount - evBase), 32'(COND_EV[c]));
            flags(rv[7:0], 1'b0, 1'b0);
        end
        // Two terms: pin0 and pin1 high, and pin2 low
        wr(pint_pkg::ADDR_PMSRC, 32'h88);
        wr(pint_pkg::ADDR_PMCOND, 32'h164);
        wr(pint_pkg::ADDR_PMCTRL, 32'h0603);
        wt(12);
        wr(pint_pkg::ADDR_INTSTAT, 32'hffff);
        wr(pint_pkg::ADDR_INTMASK, 32'h0200);
        rd(pint_pkg::ADDR_REQ, 32'h04);
        pins(target | 8'h02);
        wt(12);
        rd(pint_pkg::ADDR_REQ, 32'h06);
        rd(pint_pkg::ADDR_INTSTAT, 32'h0200);
        flags(8'h06, 1'b1, 1'b0);
        wt(4);
        wrapUp();
    end
endmodule // pint_engine_tb_top
